// File: verilog/pms_pkg.sv
// Shared constants and types for the power mode sequencer
package pms_pkg;
  // Register offsets
  localparam logic [3:0] ADDR_CTRL    = 4'h0;
  localparam logic [3:0] ADDR_DSCTRL  = 4'h1;
  localparam logic [3:0] ADDR_STATUS  = 4'h2;
  localparam logic [3:0] ADDR_IRQ_ST  = 4'h3;
  localparam logic [3:0] ADDR_IRQ_EN  = 4'h4;
  localparam logic [3:0] ADDR_IRQ_CLR = 4'h5;
  localparam logic [3:0] ADDR_WAKEF   = 4'h6;
  localparam logic [3:0] ADDR_BKP_A   = 4'h7;
  localparam logic [3:0] ADDR_BKP_B   = 4'h8;
  // Control register fields
  localparam int CTRL_RETENTION_REGULATOR_ENABLE = 0;
  localparam int DS_EN_BIT  = 0;
  // Power-save operand codes
  localparam logic [1:0] OP_SLEEP = 2'h0;
  localparam logic [1:0] OP_IDLE  = 2'h1;
  // Wake flag bits
  localparam int WF_EXTERNAL_INTERRUPT_ZERO = 0;
  localparam int WF_POR  = 1;
  localparam int WF_MASTER_CLEAR_PIN = 2;
  localparam int WF_RTC  = 3;
  localparam int WF_DSWD = 4;
  localparam int WF_W    = 5;
  // Interrupt event bits
  localparam int EV_ENTER = 0;
  localparam int EV_WAKE  = 1;
  localparam int EV_DSFAIL = 2;
  localparam int EV_BATT  = 3;
  localparam int EV_W     = 4;
  // Unlock window in cycles after the second deep sleep enable write
  localparam logic [2:0] UNLOCK_WIN = 3'h1;
  // Fixed counts
  localparam logic [15:0] ZERO16 = 16'h0000;
  // Power states
  typedef enum logic [2:0] {
    PMS_RUN   = 3'b000,
    PMS_IDLE  = 3'b001,
    PMS_SLEEP = 3'b011,
    PMS_LVSLP = 3'b010,
    PMS_DEEP  = 3'b110,
    PMS_RDEEP = 3'b111,
    PMS_BATT  = 3'b101
  } pms_state_e;
endpackage

// File: verilog/pms_sync.sv
// Two-flop synchroniser for a vector of asynchronous inputs
`timescale 1ns/1ps
module pms_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// File: verilog/pms_irq.sv
// Sticky event status with enable mask and one level interrupt
`timescale 1ns/1ps
module pms_irq #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Events and software access
  input  wire logic [W-1:0] event_set,
  input  wire logic         en_we,
  input  wire logic         clr_we,
  input  wire logic [W-1:0] wdata,
  // State
  output logic      [W-1:0] status_q,
  output logic      [W-1:0] enable_q,
  output logic              irq_q
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) enable_q <= '0;
    else if (en_we) enable_q <= wdata;
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) status_q <= '0;
    else status_q <= (status_q & ~({W{clr_we}} & wdata)) | event_set;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) irq_q <= 1'b0;
    else irq_q <= |((((status_q & ~({W{clr_we}} & wdata)) | event_set))
                    & (en_we ? wdata : enable_q));
  end
endmodule

// File: verilog/pms_core.sv
// Power mode sequencer: mode entry, wake and resume control
//
// Notes on behaviour
// R1 - Idle, Sleep, Deep Sleep need power-save instruction
// R2 - Idle stops core, peripherals keep system clock
// R3 - Sleep stops system clock and code
// R4 - Retention enabled at Sleep gives low-voltage Sleep
// R5 - Idle/Sleep wake on interrupt, watchdog, reset
// R6 - Coincident interrupt deferred, then wakes at once
// R7 - Deep Sleep freezes I/O, cuts Flash, maybe SRAM
// R8 - Software writes enable twice, then instruction
// R9 - Interrupt during unlock makes Deep Sleep fail
// R10 - Software masks interrupts during unlock
// R11 - Plain Deep Sleep exit resets, interrupt lost
// R12 - Retention Deep Sleep resumes, then services interrupt
// R13 - Deep Sleep exits on five sources; clear gives POR
// R14 - Supply loss enters battery mode; restore resets
// R15 - Retention needs config bit zero and enable set
// R16 - Enable clears if instruction late, and on exit
// R17 - Setting deep sleep enable clears wake flags
`timescale 1ns/1ps
module pms_core (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Register port
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata_q,
  // Core instruction interface
  input  wire logic        power_save_instr,
  input  wire logic [1:0]  power_save_operand,
  input  wire logic        int_pending,
  input  wire logic        int_taken,
  input  wire logic        wdt_timeout,
  input  wire logic        dev_reset,
  // Asynchronous wake and supply pins
  input  wire logic        external_interrupt_zero,
  input  wire logic        master_clear_pin_n,
  input  wire logic        por_event,
  input  wire logic        calendar_alarm,
  input  wire logic        deep_sleep_watchdog,
  input  wire logic        main_supply_ok,
  input  wire logic        low_voltage_config_bit,
  input  wire logic        calendar_on_battery_config,
  // Power controls
  output logic             core_run_q,
  output logic             sysclk_en_q,
  output logic             periph_en_q,
  output logic             sram_keep_q,
  output logic             flash_pwr_q,
  output logic             io_freeze_q,
  output logic             lv_reg_en_q,
  output logic             calendar_keep_q,
  output logic             resume_reset_q,
  output logic             resume_next_q,
  output logic             irq_q
);
  logic [1:0] rst_sync_q;
  logic       rst_n;
  logic [6:0] pins_s;
  logic       external_interrupt_zero_s, master_clear_pin_s, por_s, alarm_s, dswd_s, supply_s, calendar_on_battery_config_s;
  logic       supply_lost_s;
  pms_pkg::pms_state_e state_q;
  logic       retention_regulator_enable_q, deep_sleep_enable_q, deep_sleep_enable_wr1_q, defer_q;
  logic [2:0] win_q;
  logic [15:0] bkp_a_q, bkp_b_q;
  logic [pms_pkg::WF_W-1:0] wakef_q;
  logic [pms_pkg::EV_W-1:0] ev, ist, ien;
  logic       retention_regulator_enable_ok, wake_ls, ds_wake, ds_wr, ds_fail, asleep;

  ///////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) rst_sync_q <= 2'b00;
    else rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // Pins enter inverted where needed so the flops' reset value is idle;
  // a plain supply flag would read as lost for two edges after reset
  pms_sync #(.W(7)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({external_interrupt_zero, ~master_clear_pin_n, por_event,
             calendar_alarm, deep_sleep_watchdog, ~main_supply_ok,
             calendar_on_battery_config}),
    .q     (pins_s)
  );
  assign {external_interrupt_zero_s, master_clear_pin_s, por_s, alarm_s, dswd_s, supply_lost_s,
          calendar_on_battery_config_s} = pins_s;
  assign supply_s = !supply_lost_s;

  ///////////////////////////////////////////////////////////////////////
  assign retention_regulator_enable_ok = retention_regulator_enable_q && !low_voltage_config_bit; // see R15
  assign wake_ls  = int_pending || wdt_timeout || dev_reset; // see R5
  assign ds_wake  = external_interrupt_zero_s || por_s || master_clear_pin_s || alarm_s || dswd_s; // see R13
  assign ds_wr    = wr && addr == pms_pkg::ADDR_DSCTRL;
  // Unlock broken by a serviced interrupt or a late instruction
  assign ds_fail  = deep_sleep_enable_q && (int_taken || win_q == 3'h0); // see R9
  assign asleep   = state_q != pms_pkg::PMS_RUN;

  // Control register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) retention_regulator_enable_q <= 1'b0;
    else if (wr && addr == pms_pkg::ADDR_CTRL)
      retention_regulator_enable_q <= wdata[pms_pkg::CTRL_RETENTION_REGULATOR_ENABLE];
  end

  // Deep sleep enable: two writes in succession, short window
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      deep_sleep_enable_q     <= 1'b0;
      deep_sleep_enable_wr1_q <= 1'b0;
      win_q      <= 3'h0;
    end else begin
      deep_sleep_enable_wr1_q <= ds_wr && wdata[pms_pkg::DS_EN_BIT] && !deep_sleep_enable_wr1_q;
      if (ds_wr && wdata[pms_pkg::DS_EN_BIT] && deep_sleep_enable_wr1_q) begin
        deep_sleep_enable_q <= 1'b1; // see R8
        win_q  <= pms_pkg::UNLOCK_WIN;
      end else if (ds_fail || state_q == pms_pkg::PMS_DEEP
                   || state_q == pms_pkg::PMS_RDEEP) begin
        if (ds_fail || ds_wake) deep_sleep_enable_q <= 1'b0; // see R16
      end else if (deep_sleep_enable_q && !power_save_instr) begin
        win_q <= win_q - 3'h1;
      end
    end
  end

  // Backup registers survive every mode, battery included
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bkp_a_q <= pms_pkg::ZERO16;
      bkp_b_q <= pms_pkg::ZERO16;
    end else if (wr && addr == pms_pkg::ADDR_BKP_A) begin
      bkp_a_q <= wdata; // see R14
    end else if (wr && addr == pms_pkg::ADDR_BKP_B) begin
      bkp_b_q <= wdata;
    end
  end

  // Wake source flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) wakef_q <= '0;
    else if (ds_wr && wdata[pms_pkg::DS_EN_BIT] && deep_sleep_enable_wr1_q)
      wakef_q <= '0; // see R17
    else if (state_q == pms_pkg::PMS_DEEP || state_q == pms_pkg::PMS_RDEEP)
      wakef_q <= wakef_q | {dswd_s, alarm_s, master_clear_pin_s, por_s, external_interrupt_zero_s};
  end

  ///////////////////////////////////////////////////////////////////////
  // Mode sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= pms_pkg::PMS_RUN;
      defer_q <= 1'b0;
    end else begin
      defer_q <= 1'b0;
      if (!supply_s && state_q != pms_pkg::PMS_BATT) begin
        state_q <= pms_pkg::PMS_BATT; // see R14
      end else begin
        unique case (state_q)
          pms_pkg::PMS_RUN: if (power_save_instr) begin // see R1
            defer_q <= int_pending; // see R6
            if (power_save_operand == pms_pkg::OP_IDLE)
              state_q <= pms_pkg::PMS_IDLE;
            else if (deep_sleep_enable_q && !ds_fail)
              state_q <= retention_regulator_enable_ok ? pms_pkg::PMS_RDEEP : pms_pkg::PMS_DEEP;
            else if (retention_regulator_enable_ok)
              state_q <= pms_pkg::PMS_LVSLP; // see R4
            else
              state_q <= pms_pkg::PMS_SLEEP;
          end
          pms_pkg::PMS_IDLE, pms_pkg::PMS_SLEEP, pms_pkg::PMS_LVSLP:
            if (wake_ls || defer_q) state_q <= pms_pkg::PMS_RUN; // see R5
          pms_pkg::PMS_DEEP, pms_pkg::PMS_RDEEP:
            if (ds_wake) state_q <= pms_pkg::PMS_RUN; // see R13
          pms_pkg::PMS_BATT:
            if (supply_s) state_q <= pms_pkg::PMS_RUN;
        endcase
      end
    end
  end

  // Resume pulses: reset vector or next instruction
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resume_reset_q <= 1'b0;
      resume_next_q  <= 1'b0;
    end else begin
      resume_reset_q <= 1'b0;
      resume_next_q  <= 1'b0;
      unique case (state_q)
        pms_pkg::PMS_IDLE, pms_pkg::PMS_SLEEP, pms_pkg::PMS_LVSLP:
          resume_next_q <= supply_s && (wake_ls || defer_q);
        pms_pkg::PMS_DEEP:
          resume_reset_q <= supply_s && ds_wake; // see R11
        pms_pkg::PMS_RDEEP: begin
          resume_reset_q <= supply_s && (master_clear_pin_s || por_s); // see R13
          resume_next_q  <= supply_s && ds_wake && !master_clear_pin_s && !por_s; // see R12
        end
        pms_pkg::PMS_BATT:
          resume_reset_q <= supply_s; // see R14
        default: ;
      endcase
    end
  end

  // Power controls follow the current state, one cycle late
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_run_q      <= 1'b1;
      sysclk_en_q     <= 1'b1;
      periph_en_q     <= 1'b1;
      sram_keep_q     <= 1'b1;
      flash_pwr_q     <= 1'b1;
      io_freeze_q     <= 1'b0;
      lv_reg_en_q     <= 1'b0;
      calendar_keep_q <= 1'b1;
    end else begin
      core_run_q  <= state_q == pms_pkg::PMS_RUN; // see R2
      sysclk_en_q <= state_q == pms_pkg::PMS_RUN
                     || state_q == pms_pkg::PMS_IDLE; // see R3
      periph_en_q <= state_q == pms_pkg::PMS_RUN
                     || state_q == pms_pkg::PMS_IDLE;
      sram_keep_q <= state_q != pms_pkg::PMS_DEEP
                     && state_q != pms_pkg::PMS_BATT; // see R7
      flash_pwr_q <= state_q != pms_pkg::PMS_DEEP
                     && state_q != pms_pkg::PMS_RDEEP
                     && state_q != pms_pkg::PMS_BATT;
      io_freeze_q <= asleep && state_q != pms_pkg::PMS_IDLE;
      lv_reg_en_q <= state_q == pms_pkg::PMS_LVSLP
                     || state_q == pms_pkg::PMS_RDEEP;
      calendar_keep_q <= state_q != pms_pkg::PMS_BATT || !calendar_on_battery_config_s;
    end
  end

  ///////////////////////////////////////////////////////////////////////
  // Interrupt events
  always_comb begin
    ev = '0;
    ev[pms_pkg::EV_ENTER]  = power_save_instr && !asleep;
    ev[pms_pkg::EV_WAKE]   = resume_reset_q || resume_next_q;
    ev[pms_pkg::EV_DSFAIL] = ds_fail;
    ev[pms_pkg::EV_BATT]   = !supply_s && state_q != pms_pkg::PMS_BATT;
  end

  pms_irq #(.W(pms_pkg::EV_W)) u_irq (
    .clk       (clk),
    .rst_n     (rst_n),
    .event_set (ev),
    .en_we     (wr && addr == pms_pkg::ADDR_IRQ_EN),
    .clr_we    (wr && addr == pms_pkg::ADDR_IRQ_CLR),
    .wdata     (wdata[pms_pkg::EV_W-1:0]),
    .status_q  (ist),
    .enable_q  (ien),
    .irq_q     (irq_q)
  );

  // Read data, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rdata_q <= pms_pkg::ZERO16;
    else begin
      rdata_q <= pms_pkg::ZERO16;
      if (rd) begin
        unique case (addr)
          pms_pkg::ADDR_CTRL:   rdata_q <= {15'h0000, retention_regulator_enable_q};
          pms_pkg::ADDR_DSCTRL: rdata_q <= {15'h0000, deep_sleep_enable_q};
          pms_pkg::ADDR_STATUS: rdata_q <= {13'h0000, state_q};
          pms_pkg::ADDR_IRQ_ST: rdata_q <= {12'h000, ist};
          pms_pkg::ADDR_IRQ_EN: rdata_q <= {12'h000, ien};
          pms_pkg::ADDR_WAKEF:  rdata_q <= {11'h000, wakef_q};
          pms_pkg::ADDR_BKP_A:  rdata_q <= bkp_a_q;
          pms_pkg::ADDR_BKP_B:  rdata_q <= bkp_b_q;
          default:              rdata_q <= pms_pkg::ZERO16;
        endcase
      end
    end
  end

  ///////////////////////////////////////////////////////////////////////
  idle_core_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == pms_pkg::PMS_IDLE |=> !core_run_q && sysclk_en_q) // see R2
    else $error("idle core control wrong");
  sleep_clk_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == pms_pkg::PMS_SLEEP |=> !sysclk_en_q) // see R3
    else $error("sleep clock not stopped");
  lv_sleep_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == pms_pkg::PMS_RUN && power_save_instr && supply_s
    && power_save_operand == pms_pkg::OP_SLEEP && !deep_sleep_enable_q && retention_regulator_enable_ok
    |=> state_q == pms_pkg::PMS_LVSLP) // see R4
    else $error("low-voltage sleep not entered");
  entry_instr_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == pms_pkg::PMS_RUN && !power_save_instr && supply_s
    |=> state_q == pms_pkg::PMS_RUN) // see R1
    else $error("mode entered without instruction");
  defer_wake_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == pms_pkg::PMS_RUN && power_save_instr && int_pending
    && supply_s && power_save_operand == pms_pkg::OP_IDLE
    |=> ##1 resume_next_q || !supply_s) // see R6
    else $error("deferred interrupt did not wake");
  deep_flash_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == pms_pkg::PMS_DEEP |=> !flash_pwr_q && io_freeze_q
    && !sram_keep_q) // see R7
    else $error("deep sleep power wrong");
  deep_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == pms_pkg::PMS_DEEP && ds_wake && supply_s
    |=> resume_reset_q && !resume_next_q) // see R11
    else $error("deep sleep exit not reset");
  deep_sleep_enable_late_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(deep_sleep_enable_q) && !power_save_instr ##1 !power_save_instr
    |=> !deep_sleep_enable_q) // see R16
    else $error("deep sleep enable not cleared");
  wake_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(deep_sleep_enable_q) |-> wakef_q == '0) // see R17
    else $error("wake flags not cleared");

  run_idle_c: cover property (@(posedge clk) disable iff (!rst_n)
    state_q == pms_pkg::PMS_IDLE ##[1:20] resume_next_q);
  deep_exit_c: cover property (@(posedge clk) disable iff (!rst_n)
    state_q == pms_pkg::PMS_DEEP ##[1:50] resume_reset_q);
  rdeep_c: cover property (@(posedge clk) disable iff (!rst_n)
    state_q == pms_pkg::PMS_RDEEP);
  batt_c: cover property (@(posedge clk) disable iff (!rst_n)
    state_q == pms_pkg::PMS_BATT);
endmodule

// File: verification/pms_core_model.sv
// Processor core model that issues power-save instructions and interrupts
`timescale 1ns/1ps
module pms_core_model (
  // Clock
  input  wire logic       clk,
  // Instruction side
  output logic            power_save_instr,
  output logic      [1:0] power_save_operand,
  output logic            int_pending,
  output logic            int_taken
);
  initial begin
    power_save_instr   = 1'b0;
    power_save_operand = 2'h3;
    int_pending        = 1'b0;
    int_taken          = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts stay masked through an unlock unless brk asks otherwise
  task automatic exec(input logic [1:0] op, input bit brk, input bit pend);
    if (brk) begin
      int_taken <= 1'b1;
      @(posedge clk);
      int_taken <= 1'b0;
    end
    power_save_instr   <= 1'b1;
    power_save_operand <= op;
    if (pend)
      int_pending <= 1'b1;
    @(posedge clk);
    power_save_instr   <= 1'b0;
    power_save_operand <= ~op;
    if (pend) begin
      @(posedge clk);
      int_pending <= 1'b0;
    end
  endtask

  // One cycle of a pending enabled interrupt
  task automatic wake_irq;
    int_pending <= 1'b1;
    @(posedge clk);
    int_pending <= 1'b0;
  endtask
endmodule

// File: verification/power_mode_sequencer_tb_top.sv
// Self-checking testbench for the power mode sequencer
`timescale 1ns/1ps
module power_mode_sequencer_tb_top;
  logic        clk       = 1'b0;
  logic        reset_n   = 1'b0;
  logic [3:0]  addr      = 4'h0;
  logic [15:0] wdata     = 16'h0000;
  logic        wr        = 1'b0;
  logic        rd        = 1'b0;
  logic [4:0]  wake_v    = 5'h00;
  logic        supply_ok = 1'b1;
  logic        lv_cfg    = 1'b0;
  logic        cal_cfg   = 1'b0;
  logic        wdt_to    = 1'b0;
  logic        dev_rst   = 1'b0;
  logic [15:0] rdata_q;
  wire  [7:0]  ctl;
  logic        psi, pint, ptak, res_rst, res_nxt, irq_q;
  logic [1:0]  pop;
  int          error_cnt = 0;
  int          checked = 0;
  int          n_next = 0;
  int          n_rst = 0;
  int          b_next, b_rst, i, r, k;
  bit          er;

  always #12.5 clk = ~clk;

  always @(posedge clk) begin
    if (res_nxt === 1'b1) n_next <= n_next + 1;
    if (res_rst === 1'b1) n_rst <= n_rst + 1;
  end

  pms_core pms_core_inst (
    .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata_q(rdata_q), .power_save_instr(psi),
    .power_save_operand(pop), .int_pending(pint), .int_taken(ptak),
    .wdt_timeout(wdt_to), .dev_reset(dev_rst),
    .external_interrupt_zero(wake_v[0]), .master_clear_pin_n(~wake_v[2]),
    .por_event(wake_v[1]), .calendar_alarm(wake_v[3]),
    .deep_sleep_watchdog(wake_v[4]), .main_supply_ok(supply_ok),
    .low_voltage_config_bit(lv_cfg), .calendar_on_battery_config(cal_cfg),
    .core_run_q(ctl[7]), .sysclk_en_q(ctl[6]), .periph_en_q(ctl[5]),
    .sram_keep_q(ctl[4]), .flash_pwr_q(ctl[3]), .io_freeze_q(ctl[2]),
    .lv_reg_en_q(ctl[1]), .calendar_keep_q(ctl[0]),
    .resume_reset_q(res_rst), .resume_next_q(res_nxt), .irq_q(irq_q)
  );

  pms_core_model pms_core_model_inst (
    .clk(clk), .power_save_instr(psi), .power_save_operand(pop),
    .int_pending(pint), .int_taken(ptak)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    if (error_cnt == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, exp, mask);
    checked++;
    if ((got & mask) !== (exp & mask)) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // n back-to-back write cycles of the same word
  task automatic wr1(input logic [3:0] a, input logic [15:0] d, input int n);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    repeat (n) @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_raw(input logic [3:0] a, output logic [15:0] v);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata_q;
    @(posedge clk);
  endtask

  task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] v;
    rd_raw(a, v);
    chk(v, exp, 16'hffff);
  endtask

  // Poll the mode code with a bounded number of reads
  task automatic wait_st(input logic [15:0] exp);
    logic [15:0] v;
    for (int j = 0; j < 40; j++) begin
      rd_raw(pms_pkg::ADDR_STATUS, v);
      if (v === exp) break;
    end
    chk(v, exp, 16'hffff);
    if (v !== exp) close_out();
  endtask

  task automatic ctlc(input logic [7:0] e, m);
    #1 chk({8'h00, ctl}, {8'h00, e}, {8'h00, m});
    @(posedge clk);
  endtask

  task automatic snap;
    b_next = n_next;
    b_rst  = n_rst;
  endtask

  task automatic pulses(input int en, input int erst);
    chk(16'(n_next - b_next), 16'(en), 16'hffff);
    chk(16'(n_rst - b_rst), 16'(erst), 16'hffff);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    cyc(8);
    ctlc(8'hf9, 8'hff);
    rdc(pms_pkg::ADDR_STATUS, 16'h0000);
    rdc(4'hf, 16'h0000);
    // Idle entry and interrupt wake
    snap();
    pms_core_model_inst.exec(pms_pkg::OP_IDLE, 1'b0, 1'b0);
    rdc(pms_pkg::ADDR_STATUS, 16'h0001);
    ctlc(8'h79, 8'hff);
    pms_core_model_inst.wake_irq();
    wait_st(16'h0000);
    pulses(1, 0);
    // Event status, mask and clear
    wr1(pms_pkg::ADDR_IRQ_ST, 16'h0000, 1);
    rdc(pms_pkg::ADDR_IRQ_ST, 16'h0003);
    chk({15'h0000, irq_q}, 16'h0000, 16'hffff);
    wr1(pms_pkg::ADDR_IRQ_EN, 16'h0001, 1);
    cyc(2);
    ctlc(8'hf9, 8'hff);
    chk({15'h0000, irq_q}, 16'h0001, 16'hffff);
    wr1(pms_pkg::ADDR_IRQ_CLR, 16'h000f, 1);
    cyc(3);
    chk({15'h0000, irq_q}, 16'h0000, 16'hffff);
    rdc(pms_pkg::ADDR_IRQ_ST, 16'h0000);
    // Sleep, low-voltage sleep, and sleep with regulator barred by config
    for (i = 0; i < 3; i++) begin
      lv_cfg <= (i == 2);
      wr1(pms_pkg::ADDR_CTRL, 16'(i != 0), 1);
      cyc(1);
      snap();
      pms_core_model_inst.exec((i == 1) ? 2'h2 : pms_pkg::OP_SLEEP, 0, 0);
      rdc(pms_pkg::ADDR_STATUS, (i == 1) ? 16'h2 : 16'h3);
      ctlc((i == 1) ? 8'h12 : 8'h10, 8'hd2);
      if (i < 2) begin
        {dev_rst, wdt_to} <= (i == 0) ? 2'b01 : 2'b10;
        @(posedge clk);
        {dev_rst, wdt_to} <= 2'b00;
      end else
        pms_core_model_inst.wake_irq();
      wait_st(16'h0000);
      pulses(1, 0);
    end
    lv_cfg <= 1'b0;
    // Interrupt together with the instruction
    wr1(pms_pkg::ADDR_IRQ_CLR, 16'h000f, 1);
    snap();
    pms_core_model_inst.exec(pms_pkg::OP_IDLE, 1'b0, 1'b1);
    wait_st(16'h0000);
    pulses(1, 0);
    rdc(pms_pkg::ADDR_IRQ_ST, 16'h0003);
    // Deep sleep, plain and with retention, for every wake source
    for (r = 0; r < 2; r++) begin
      for (k = 0; k < 5; k++) begin
        wr1(pms_pkg::ADDR_CTRL, 16'(r), 1);
        cyc(1);
        wr1(pms_pkg::ADDR_DSCTRL, 16'h0001, 2);
        pms_core_model_inst.exec(pms_pkg::OP_SLEEP, 1'b0, 1'b0);
        rdc(pms_pkg::ADDR_STATUS, r ? 16'h7 : 16'h6);
        ctlc(r ? 8'h17 : 8'h05, 8'hff);
        wdt_to <= 1'b1;
        pms_core_model_inst.wake_irq();
        wdt_to <= 1'b0;
        cyc(4);
        rdc(pms_pkg::ADDR_STATUS, r ? 16'h7 : 16'h6);
        snap();
        wake_v <= 5'(1 << k);
        cyc(4);
        wake_v <= 5'h00;
        wait_st(16'h0000);
        rdc(pms_pkg::ADDR_WAKEF, 16'(1 << k));
        rdc(pms_pkg::ADDR_DSCTRL, 16'h0000);
        er = (r == 0) || (k == pms_pkg::WF_POR) || (k == pms_pkg::WF_MASTER_CLEAR_PIN);
        pulses(int'(!er), int'(er));
      end
    end
    // Enable set clears wake flags; late instruction lets it lapse
    wr1(pms_pkg::ADDR_DSCTRL, 16'h0001, 2);
    cyc(3);
    rdc(pms_pkg::ADDR_WAKEF, 16'h0000);
    rdc(pms_pkg::ADDR_DSCTRL, 16'h0000);
    // Interrupt serviced inside the unlock breaks deep sleep entry
    wr1(pms_pkg::ADDR_CTRL, 16'h0000, 1);
    cyc(1);
    wr1(pms_pkg::ADDR_IRQ_CLR, 16'h000f, 1);
    cyc(1);
    wr1(pms_pkg::ADDR_DSCTRL, 16'h0001, 2);
    pms_core_model_inst.exec(pms_pkg::OP_SLEEP, 1'b1, 1'b0);
    rdc(pms_pkg::ADDR_STATUS, 16'h0003);
    rdc(pms_pkg::ADDR_IRQ_ST, 16'h0005);
    pms_core_model_inst.wake_irq();
    wait_st(16'h0000);
    // Supply loss with and without the calendar kept
    wr1(pms_pkg::ADDR_BKP_A, 16'h5a3c, 1);
    cyc(1);
    wr1(pms_pkg::ADDR_BKP_B, 16'hc3a5, 1);
    for (i = 0; i < 2; i++) begin
      cal_cfg   <= 1'(i);
      cyc(1);
      supply_ok <= 1'b0;
      cyc(4);
      rdc(pms_pkg::ADDR_STATUS, 16'h0005);
      ctlc({7'h00, i == 0}, 8'h81);
      snap();
      supply_ok <= 1'b1;
      wait_st(16'h0000);
      pulses(0, 1);
      rdc(pms_pkg::ADDR_BKP_A, 16'h5a3c);
      rdc(pms_pkg::ADDR_BKP_B, 16'hc3a5);
    end
    close_out();
  end
endmodule
